// file: pkg/fwsr_pkg.sv
package fwsr_pkg;

  // Flash address width and software bus address width
  localparam int FLASH_AW = 19;
  localparam int APB_AW   = 8;

  // Offsets of the controller registers
  localparam logic [APB_AW-1:0] REG_CTRL  = 8'h00;
  localparam logic [APB_AW-1:0] REG_ADDR  = 8'h04;
  localparam logic [APB_AW-1:0] REG_WDATA = 8'h08;
  localparam logic [APB_AW-1:0] REG_STAT  = 8'h0C;

  // Command codes written to the control register
  localparam logic [1:0] CMD_NONE  = 2'h0;
  localparam logic [1:0] CMD_WRITE = 2'h1;
  localparam logic [1:0] CMD_READ  = 2'h2;
  localparam logic [1:0] CMD_POLL  = 2'h3;

  // Status register field positions
  localparam int ST_BUSY  = 0;
  localparam int ST_DONE  = 1;
  localparam int ST_FAIL  = 2;
  localparam int ST_TIMER = 3;
  localparam int ST_TOG2  = 4;
  localparam int ST_ERR   = 5;
  localparam int ST_BYTE  = 8;

  // Positions of the status bits on the flash data lines
  localparam int DQ_POLL  = 7;
  localparam int DQ_TOG1  = 6;
  localparam int DQ_FAIL  = 5;
  localparam int DQ_TIMER = 3;
  localparam int DQ_TOG2  = 2;

  // Reset command byte, written to any address
  localparam logic [7:0] RESET_CMD_DATA = 8'hF0;

  // Values after reset
  localparam logic [FLASH_AW-1:0] ADDR_RST  = 19'h00000;
  localparam logic [7:0]          WDATA_RST = 8'h00;

  // Bus cycle timing
  localparam int CLK_NS    = 20;
  localparam int T_STRB_NS = 90;
  localparam int T_OEH_NS  = 10;
  localparam int STRB_CYC  = (T_STRB_NS + CLK_NS - 1) / CLK_NS;
  localparam int GAP_CYC   = (T_OEH_NS + CLK_NS - 1) / CLK_NS;
  localparam int CNT_W     = 4;

  // Flash pin bundle
  typedef struct packed {
    logic                ce_n;
    logic                oe_n;
    logic                we_n;
    logic [FLASH_AW-1:0] addr;
    logic [7:0]          dq_o;
    logic                dq_oe;
  } fwsr_pins_s;

  localparam fwsr_pins_s PINS_IDLE = '{1'b1, 1'b1, 1'b1, 19'h00000,
                                       8'h00, 1'b0};

  // Bus cycle phases
  typedef enum logic [3:0] {
    C_IDLE  = 4'h1,
    C_SETUP = 4'h2,
    C_STRB  = 4'h4,
    C_HOLD  = 4'h8
  } fwsr_cyc_e;

  // Sequencer states
  typedef enum logic [6:0] {
    M_IDLE = 7'h01,
    M_WR   = 7'h02,
    M_RD   = 7'h04,
    M_PA   = 7'h08,
    M_PB   = 7'h10,
    M_CHK  = 7'h20,
    M_RST  = 7'h40
  } fwsr_main_e;

endpackage

// file: rtl/fwsr_bus_cycle.sv
`timescale 1ns/10ps
module fwsr_bus_cycle #(
  parameter int STRB_CYC = fwsr_pkg::STRB_CYC,
  parameter int GAP_CYC  = fwsr_pkg::GAP_CYC
) (
  // Clock, reset, enable
  input  wire logic                          pclk,
  input  wire logic                          presetn,
  input  wire logic                          en,
  // Cycle request
  input  wire logic                          start,
  input  wire logic                          wr,
  input  wire logic [fwsr_pkg::FLASH_AW-1:0] addr,
  input  wire logic [7:0]                    wdata,
  output logic                               done,
  output logic [7:0]                         rdata,
  // Flash pins
  output fwsr_pkg::fwsr_pins_s               pins,
  input  wire logic [7:0]                    dq_i
);
  import fwsr_pkg::*;

  localparam logic [CNT_W-1:0] STRB_LAST = CNT_W'(STRB_CYC - 1);
  localparam logic [CNT_W-1:0] GAP_LAST  = CNT_W'(GAP_CYC - 1);

  fwsr_cyc_e        st_r;
  logic [CNT_W-1:0] cnt_r;

  // Phase sequencing: setup, strobe low, chip select recovery
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r  <= C_IDLE;
      cnt_r <= '0;
    end else if (en) begin
      unique case (st_r)
        C_IDLE: begin
          if (start) st_r <= C_SETUP;
        end
        C_SETUP: begin
          st_r  <= C_STRB;
          cnt_r <= STRB_LAST;
        end
        C_STRB: begin
          if (cnt_r == '0) begin
            st_r  <= C_HOLD;
            cnt_r <= GAP_LAST;
          end else begin
            cnt_r <= cnt_r - 1'b1;
          end
        end
        C_HOLD: begin
          if (cnt_r == '0) st_r <= C_IDLE;
          else cnt_r <= cnt_r - 1'b1;
        end
      endcase
    end
  end

  // Pin drive, read capture and completion pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pins  <= PINS_IDLE;
      rdata <= 8'h00;
      done  <= 1'b0;
    end else if (en) begin
      done <= 1'b0;
      unique case (st_r)
        C_IDLE: begin
          if (start) begin
            pins.addr  <= addr;
            pins.dq_o  <= wdata;
            pins.dq_oe <= wr;
            pins.ce_n  <= 1'b0;
          end
        end
        C_SETUP: begin
          pins.oe_n <= wr;
          pins.we_n <= ~wr;
        end
        C_STRB: begin
          if (cnt_r == '0) begin
            pins.oe_n <= 1'b1;
            pins.we_n <= 1'b1;
            if (!pins.oe_n) rdata <= dq_i; // Sample at end of access
          end
        end
        C_HOLD: begin
          pins.ce_n  <= 1'b1; // Separates successive reads
          pins.dq_oe <= 1'b0;
          if (cnt_r == '0) done <= 1'b1;
        end
      endcase
    end
  end

  a_strobes_apart: assert property (@(posedge pclk) disable iff (!presetn)
    !(!pins.oe_n && !pins.we_n))
    else $error("read and write strobes low together");

  a_no_drive_read: assert property (@(posedge pclk) disable iff (!presetn)
    !pins.oe_n |-> !pins.dq_oe)
    else $error("data driven during read strobe");

  a_strobe_in_ce: assert property (@(posedge pclk) disable iff (!presetn)
    (!pins.oe_n || !pins.we_n) |-> !pins.ce_n)
    else $error("strobe low outside chip select");

endmodule // fwsr_bus_cycle

// file: rtl/fwsr_ctrl.sv
// Behaviour
// - Host reads polling and bit two status at a valid address.
// - Host reads twice in a row; equal toggle bits mean finished.
// - Toggling with fail bit high: recheck once, still toggling means fail.
// - Host restarts status check from a fresh double read on return.
// - After a failure the host issues the reset command.
// - Host may ignore timer bit only if commands spaced under 50 us.
// - Host confirms acceptance, then checks timer bit around each command.
// - Reset command is one write of F0 to any address.
`timescale 1ns/10ps
module fwsr_ctrl #(
  parameter int STRB_CYC = fwsr_pkg::STRB_CYC,
  parameter int GAP_CYC  = fwsr_pkg::GAP_CYC
) (
  // Clock, reset, enable
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  input  wire logic                        en,
  // APB slave
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [fwsr_pkg::APB_AW-1:0] paddr,
  input  wire logic [31:0]                 pwdata,
  output logic [31:0]                      prdata,
  output logic                             pready,
  output logic                             pslverr,
  // Flash pins
  output fwsr_pkg::fwsr_pins_s             flash_pins,
  input  wire logic [7:0]                  flash_dq_i
);
  import fwsr_pkg::*;

  fwsr_main_e          st_r;
  logic [FLASH_AW-1:0] addr_r;
  logic [7:0]          wdata_r;
  logic                busy_r;
  logic                done_r;
  logic                fail_r;
  logic                timer_r;
  logic                tog2_r;
  logic                err_r;
  logic [7:0]          byte_r;
  logic [7:0]          prev_r;
  logic                recheck_r;
  logic                cyc_start_r;
  logic                cyc_wr_r;
  logic [FLASH_AW-1:0] cyc_addr_r;
  logic [7:0]          cyc_wdata_r;
  logic                cyc_done;
  logic [7:0]          cyc_rdata;
  logic                access;
  logic                wr_fire;
  logic                hit;
  logic [31:0]         rd_mux;
  logic [1:0]          go_cmd;
  logic                go;
  logic                done_clr;
  logic                tog1_same;

  // APB phase decode; a write lands on the edge that sees pready high
  assign access  = psel & penable & ~pready;
  assign wr_fire = psel & penable & pready & pwrite;
  assign go_cmd  = pwdata[1:0];
  assign go      = wr_fire && (paddr == REG_CTRL) && (go_cmd != CMD_NONE)
                   && !busy_r;
  assign done_clr = wr_fire && (paddr == REG_STAT) && pwdata[ST_DONE];

  // Read multiplexer and address hit
  always_comb begin
    rd_mux = 32'h0000_0000;
    hit    = 1'b1;
    unique case (paddr)
      REG_CTRL:  rd_mux = 32'h0000_0000;
      REG_ADDR:  rd_mux[FLASH_AW-1:0] = addr_r;
      REG_WDATA: rd_mux[7:0] = wdata_r;
      REG_STAT: begin
        rd_mux[ST_BUSY]           = busy_r;
        rd_mux[ST_DONE]           = done_r;
        rd_mux[ST_FAIL]           = fail_r;
        rd_mux[ST_TIMER]          = timer_r;
        rd_mux[ST_TOG2]           = tog2_r;
        rd_mux[ST_ERR]            = err_r;
        rd_mux[ST_BYTE+7:ST_BYTE] = byte_r;
      end
      default: hit = 1'b0;
    endcase
  end

  // APB answer: one wait cycle, then registered data and error
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else if (en) begin
      pready <= access;
      if (access) begin
        prdata  <= pwrite ? 32'h0000_0000 : rd_mux;
        pslverr <= ~hit;
      end
    end
  end

  // Software address and data registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      addr_r  <= ADDR_RST;
      wdata_r <= WDATA_RST;
    end else if (en && wr_fire) begin
      if (paddr == REG_ADDR) addr_r <= pwdata[FLASH_AW-1:0];
      if (paddr == REG_WDATA) wdata_r <= pwdata[7:0];
    end
  end

  // Toggle bit one compared between the two latest reads
  assign tog1_same = (prev_r[DQ_TOG1] == cyc_rdata[DQ_TOG1]);

  // Command sequencer and flash cycle requests
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r        <= M_IDLE;
      cyc_start_r <= 1'b0;
      cyc_wr_r    <= 1'b0;
      cyc_addr_r  <= ADDR_RST;
      cyc_wdata_r <= WDATA_RST;
      prev_r      <= 8'h00;
      recheck_r   <= 1'b0;
    end else if (en) begin
      cyc_start_r <= 1'b0;
      unique case (st_r)
        M_IDLE: begin
          if (go) begin
            cyc_start_r <= 1'b1;
            cyc_addr_r  <= addr_r;
            cyc_wdata_r <= wdata_r;
            cyc_wr_r    <= (go_cmd == CMD_WRITE);
            recheck_r   <= 1'b0;
            unique case (go_cmd)
              CMD_WRITE: st_r <= M_WR;
              CMD_READ:  st_r <= M_RD;
              default:   st_r <= M_PA;
            endcase
          end
        end
        M_WR, M_RD, M_RST: begin
          if (cyc_done) st_r <= M_IDLE;
        end
        M_PA: begin
          if (cyc_done) begin
            prev_r      <= cyc_rdata;
            cyc_start_r <= 1'b1;
            st_r        <= M_PB;
          end
        end
        M_PB: begin
          if (cyc_done) st_r <= M_CHK;
        end
        M_CHK: begin
          if (tog1_same) begin
            st_r <= M_IDLE;
          end else if (recheck_r) begin
            cyc_start_r <= 1'b1;
            cyc_wr_r    <= 1'b1;
            cyc_wdata_r <= RESET_CMD_DATA;
            st_r        <= M_RST;
          end else begin
            recheck_r   <= cyc_rdata[DQ_FAIL];
            prev_r      <= cyc_rdata;
            cyc_start_r <= 1'b1;
            st_r        <= M_PB;
          end
        end
      endcase
    end
  end

  // Busy flag follows the sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_r <= 1'b0;
    end else if (en) begin
      if (go) busy_r <= 1'b1;
      else if (st_r == M_IDLE) busy_r <= 1'b0;
      else if ((st_r == M_CHK) && tog1_same) busy_r <= 1'b0;
      else if ((st_r != M_PA) && (st_r != M_PB) && (st_r != M_CHK)
               && cyc_done) busy_r <= 1'b0;
    end
  end

  // Sticky completion flag; a new completion beats a clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_r <= 1'b0;
    end else if (en) begin
      if (busy_r && !go && st_r != M_IDLE &&
          (((st_r == M_CHK) && tog1_same) ||
           (cyc_done && (st_r != M_PA) && (st_r != M_PB))))
        done_r <= 1'b1;
      else if (done_clr || go) done_r <= 1'b0;
    end
  end

  // Failure flag: set after the reset write, cleared by the next command
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fail_r <= 1'b0;
    end else if (en) begin
      if ((st_r == M_RST) && cyc_done) fail_r <= 1'b1;
      else if (go) fail_r <= 1'b0;
    end
  end

  // Ignored command while busy; sticky, cleared by write one
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err_r <= 1'b0;
    end else if (en) begin
      if (wr_fire && (paddr == REG_CTRL) && (go_cmd != CMD_NONE) && busy_r)
        err_r <= 1'b1;
      else if (wr_fire && (paddr == REG_STAT) && pwdata[ST_ERR])
        err_r <= 1'b0;
    end
  end

  // Last byte read and the status bits taken from it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      byte_r  <= 8'h00;
      timer_r <= 1'b0;
      tog2_r  <= 1'b0;
    end else if (en) begin
      if (cyc_done && !cyc_wr_r) begin
        byte_r  <= cyc_rdata;
        timer_r <= cyc_rdata[DQ_TIMER];
      end
      if ((st_r == M_PB) && cyc_done)
        tog2_r <= prev_r[DQ_TOG2] ^ cyc_rdata[DQ_TOG2];
    end
  end

  // Flash bus cycle engine
  fwsr_bus_cycle #(
    .STRB_CYC (STRB_CYC),
    .GAP_CYC  (GAP_CYC)
  ) u_cyc (
    .pclk    (pclk),
    .presetn (presetn),
    .en      (en),
    .start   (cyc_start_r),
    .wr      (cyc_wr_r),
    .addr    (cyc_addr_r),
    .wdata   (cyc_wdata_r),
    .done    (cyc_done),
    .rdata   (cyc_rdata),
    .pins    (flash_pins),
    .dq_i    (flash_dq_i)
  );

  a_reset_byte: assert property (@(posedge pclk)
    disable iff (!presetn)
    (st_r == M_RST) |-> (cyc_wr_r && cyc_wdata_r == 8'hF0))
    else $error("reset write does not carry F0");

  a_poll_addr: assert property (@(posedge pclk)
    disable iff (!presetn)
    (cyc_start_r && !cyc_wr_r) |-> (cyc_addr_r == addr_r))
    else $error("status read away from software address");

  a_fail_path: assert property (@(posedge pclk)
    disable iff (!presetn)
    $rose(fail_r) |-> ($past(st_r) == M_RST))
    else $error("failure flagged without reset write");

  a_ok_equal: assert property (@(posedge pclk)
    disable iff (!presetn)
    (en && st_r == M_CHK && tog1_same) |=> (st_r == M_IDLE && !fail_r))
    else $error("equal toggle reads did not finish the poll");

  a_recheck_fail: assert property (@(posedge pclk)
    disable iff (!presetn)
    (en && st_r == M_CHK && !tog1_same && recheck_r) |=> (st_r == M_RST))
    else $error("toggling after recheck did not lead to reset");

  a_fresh_pair: assert property (@(posedge pclk)
    disable iff (!presetn)
    (en && go && go_cmd == CMD_POLL) |=> (st_r == M_PA && !recheck_r))
    else $error("poll did not restart from a double read");

  a_busy_done: assert property (@(posedge pclk)
    disable iff (!presetn)
    $rose(done_r) |-> !busy_r)
    else $error("completion flagged while busy");

  a_done_sticky: assert property (@(posedge pclk) disable iff (!presetn)
    (done_r && !done_clr && !go) |=> done_r)
    else $error("completion flag lost without a clear");

  a_pready_pulse: assert property (@(posedge pclk) disable iff (!presetn)
    pready |=> !pready)
    else $error("pready held for two cycles");

endmodule // fwsr_ctrl

// file: dv/fwsr_flash_model.sv
`timescale 1ns/10ps
module fwsr_flash_model (
  // Flash pins
  input  wire fwsr_pkg::fwsr_pins_s pins,
  input  wire logic [7:0]           dq_in,
  output logic [7:0]                dq_out,
  // Scenario control
  input  wire logic                 start,
  input  wire logic [2:0]           op,
  input  wire logic [7:0]           len,
  output logic [7:0]                last_wr,
  output int                        rd_cnt
);
  import fwsr_pkg::*;

  // Modes: 0 array, 1 program, 2 erase, 3 erase suspend, 4 failed
  logic [2:0] mode_r = 3'h0;
  logic [7:0] left_r = 8'h00;
  logic [7:0] stat;
  logic       tog1_r = 1'b0;
  logic       tog2_r = 1'b1;
  // Only one sector is chosen for erase, the rest stay untouched
  wire        in_sect = (pins.addr[18:16] == 3'h2);

  initial begin
    rd_cnt  = 0;
    last_wr = 8'h00;
  end

  // Status byte replaces array data while an algorithm runs
  always_comb begin
    stat = pins.addr[7:0] ^ 8'hA5;
    case (mode_r)
      3'h1: stat = {~last_wr[7], tog1_r, 6'h00};
      3'h2: stat = {1'b0, tog1_r, 3'b001,
                    in_sect & tog2_r, 2'b00};
      3'h3: if (in_sect) stat = {1'b1, tog1_r, 3'h0, tog2_r, 2'b00};
      3'h4: stat = {~last_wr[7], tog1_r, 1'b1, 5'h00};
      default: ;
    endcase
  end

  // Released lines show the inverse rather than a stale value
  assign dq_out = (!pins.ce_n && !pins.oe_n) ? stat : ~stat;

  // Each completed read advances the toggle bits and the algorithm
  always @(posedge pins.oe_n) begin
    if (pins.ce_n === 1'b0) begin
      rd_cnt++;
      if (mode_r inside {3'h1, 3'h2, 3'h4}) tog1_r = ~tog1_r;
      if (mode_r inside {3'h2, 3'h3} && in_sect) tog2_r = ~tog2_r;
      if (mode_r inside {3'h1, 3'h2} && left_r != 8'h00) left_r--;
      if (mode_r inside {3'h1, 3'h2} && left_r == 8'h00) mode_r = 3'h0;
    end
  end

  // Writes latch on the rising write strobe; the reset byte aborts
  always @(posedge pins.we_n) begin
    if (pins.ce_n === 1'b0) begin
      last_wr = dq_in;
      if (dq_in == RESET_CMD_DATA) mode_r = 3'h0;
    end
  end

  // Bench starts an algorithm of a given length in reads
  always @(posedge start) begin
    mode_r = op;
    left_r = len;
  end
endmodule // fwsr_flash_model

// file: dv/tb_top.sv
`timescale 1ns/10ps
module tb_top;
  import fwsr_pkg::*;

  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, e, en;
  logic [7:0]  paddr, m_dq, dq_wire, m_wr, m_len, b1, b2;
  logic [31:0] pwdata, prdata, r, rv;
  logic [2:0]  m_op;
  logic        m_start;
  fwsr_pins_s  pins, pz;
  int          m_rd, error_cnt, num_checks, seed, n0;

  // Controller wins the data wire while it drives
  assign dq_wire = pins.dq_oe ? pins.dq_o : m_dq;

  fwsr_ctrl DUT (.pclk(pclk), .presetn(presetn), .en(en), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .flash_pins(pins), .flash_dq_i(dq_wire));

  fwsr_flash_model u_flash (.pins(pins), .dq_in(dq_wire), .dq_out(m_dq),
    .start(m_start), .op(m_op), .len(m_len), .last_wr(m_wr),
    .rd_cnt(m_rd));

  // Array content of the flash model
  function automatic logic [7:0] arr(input logic [18:0] a);
    return a[7:0] ^ 8'hA5;
  endfunction

  // Status word after a clean finish with a given byte
  function automatic logic [31:0] sx(input logic [7:0] b);
    return {16'h0000, b, 8'h02};
  endfunction

  task automatic chk(input string nm, input logic [31:0] got, exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // One APB transfer; result lands in r and e
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) error_cnt++;
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic rdc(input string nm, input logic [7:0] a,
                     input logic [31:0] m, exp);
    apb(1'b0, a, 32'h00000000);
    chk(nm, r & m, exp);
  endtask

  task automatic go(input logic [18:0] a, input logic [1:0] c);
    apb(1'b1, REG_ADDR, {13'h0000, a});
    apb(1'b1, REG_CTRL, {30'h00000000, c});
  endtask

  // Waits until busy clears; r keeps the final status word
  task automatic idle;
    int n;
    n = 0;
    do begin
      apb(1'b0, REG_STAT, 32'h00000000);
      n++;
    end while (r[ST_BUSY] !== 1'b0 && n < 400);
    if (n >= 400) error_cnt++;
  endtask

  task automatic cmd(input logic [18:0] a, input logic [1:0] c);
    go(a, c);
    idle();
  endtask

  task automatic mstart(input logic [2:0] o, input logic [7:0] l);
    m_op    <= o;
    m_len   <= l;
    m_start <= 1'b1;
    @(posedge pclk);
    m_start <= 1'b0;
    @(posedge pclk);
    n0 = m_rd;
  endtask

  task automatic conclude;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Clock
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  // Watchdog against a hung handshake or poll
  initial begin
    #1000000;
    error_cnt++;
    conclude();
  end

  // Main sequence
  initial begin
    seed = 32'h20AD;
    error_cnt = 0;
    num_checks = 0;
    {presetn, psel, penable, pwrite, m_start} = 5'h00;
    en = 1'b1;
    {paddr, pwdata, m_op, m_len} = '0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    // Reset values and the unmapped hole
    rdc("stat_rst", REG_STAT, 32'hFFFFFFFF, 32'h00000000);
    rdc("addr_rst", REG_ADDR, 32'hFFFFFFFF, {13'h0000, ADDR_RST});
    rdc("wdata_rst", REG_WDATA, 32'hFFFFFFFF, {24'h000000, WDATA_RST});
    rdc("hole_rd", 8'h10, 32'hFFFFFFFF, 32'h00000000);
    chk("hole_err", {31'h00000000, e}, 32'h00000001);
    // Random words read back in their fields, then array reads there
    for (int i = 0; i < 4; i++) begin
      rv = $random(seed);
      apb(1'b1, REG_WDATA, rv);
      rdc("wdata_rb", REG_WDATA, 32'hFFFFFFFF, rv & 32'h000000FF);
      apb(1'b1, REG_ADDR, rv);
      rdc("addr_rb", REG_ADDR, 32'hFFFFFFFF, rv & 32'h0007FFFF);
      apb(1'b1, REG_CTRL, {30'h00000000, CMD_READ});
      idle();
      chk("arr_rd", r & 32'h0000FF07, sx(arr(rv[18:0])));
    end
    // Program: datum, status read, then poll to completion
    apb(1'b1, REG_WDATA, 32'h0000003C);
    cmd(19'h01234, CMD_WRITE);
    chk("prog_dat", {24'h000000, m_wr}, 32'h0000003C);
    mstart(3'h1, 8'h05);
    cmd(19'h01234, CMD_READ);
    chk("prog_st", r & 32'h0000A007, 32'h00008002);
    n0 = m_rd;
    cmd(19'h01234, CMD_POLL);
    chk("prog_poll", r & 32'h0000FF17, sx(arr(19'h01234)));
    chk("prog_n", 32'((m_rd - n0) inside {5, 6}), 32'h1);
    // Endless toggling with the fail bit: recheck, reset, array again
    mstart(3'h4, 8'h00);
    cmd(19'h01234, CMD_POLL);
    chk("fail_st", r & 32'h00000007, 32'h00000006);
    chk("fail_n", 32'(m_rd - n0), 32'h3);
    chk("fail_rst", {24'h000000, m_wr}, {24'h000000, RESET_CMD_DATA});
    cmd(19'h01234, CMD_READ);
    chk("fail_arr", r & 32'h0000FF07, sx(arr(19'h01234)));
    // Erase: timer bit, both toggle bits, sector dependence
    mstart(3'h2, 8'h14);
    cmd(19'h20010, CMD_READ);
    chk("er_st1", r & 32'h0000A00F, 32'h0000000A);
    b1 = r[15:8];
    cmd(19'h20010, CMD_READ);
    b2 = r[15:8];
    chk("er_t1", {31'h0, b1[6] ^ b2[6]}, 32'h1);
    chk("er_t2", {31'h0, b1[2] ^ b2[2]}, 32'h1);
    cmd(19'h00010, CMD_READ);
    chk("er_out", {30'h0, r[14], r[10]}, {30'h0, ~b2[6], 1'b0});
    // Suspend: bit one still, array outside the sector
    mstart(3'h3, 8'h00);
    cmd(19'h20010, CMD_READ);
    chk("sus_st", r & 32'h0000A00F, 32'h00008002);
    cmd(19'h00010, CMD_READ);
    chk("sus_arr", r & 32'h0000FF07, sx(arr(19'h00010)));
    n0 = m_rd;
    cmd(19'h20010, CMD_POLL);
    chk("sus_poll", r & 32'h00000017, 32'h00000012);
    chk("sus_n", 32'(m_rd - n0), 32'h2);
    // Erase runs to completion under polling
    mstart(3'h2, 8'h06);
    cmd(19'h20010, CMD_POLL);
    chk("er_poll", r & 32'h0000FF07, sx(arr(19'h20010)));
    chk("er_n", 32'((m_rd - n0) inside {7, 8}), 32'h1);
    // Clock enable low freezes a flash cycle in flight, then it resumes
    go(19'h00030, CMD_READ);
    en <= 1'b0;
    @(posedge pclk);
    pz = pins;
    repeat (6) @(posedge pclk);
    chk("en_hold", {31'h00000000, pins === pz}, 32'h00000001);
    chk("en_ce", {31'h00000000, pins.ce_n}, 32'h00000000);
    en <= 1'b1;
    idle();
    chk("en_arr", r & 32'h0000FF07, sx(arr(19'h00030)));
    // A second command while busy is refused and flagged
    go(19'h00020, CMD_READ);
    apb(1'b1, REG_CTRL, {30'h00000000, CMD_READ});
    idle();
    chk("busy_ign", r & 32'h00000020, 32'h00000020);
    apb(1'b1, REG_STAT, 32'h00000022);
    rdc("w1c", REG_STAT, 32'h00000022, 32'h00000000);
    apb(1'b1, REG_CTRL, {30'h00000000, CMD_NONE});
    rdc("cmd_none", REG_STAT, 32'h00000003, 32'h00000000);
    conclude();
  end
endmodule // tb_top
